// File: rtl/etcc_pkg.sv
// etcc_pkg: register map, field positions, states and carriers of the trace capture core.
// assumes an AXI4-Lite master on aclk and a slow sample clock arriving as a plain input.
// ==========================================================================
// Behaviour
// - one core traces between 1 and 512 user signals.
// - buffer depth is a build parameter, a power of two from 16 to 65536.
// - single or multiple trigger capture; single trigger after reset.
// - samples per trigger at least max(8, depth/256) in multiple mode.
// - without gating, every sample clock from a trigger on stores one sample, in multiple mode until its segment ends.
// - sample-enable gating is optional and off after reset.
// - sample-enable polarity selectable; active high after reset.
// - with gating, samples are stored only while the enable is active.
// - a trigger while the enable is inactive stores nothing for that cycle.
// - with gating, trigger position is reported as a five-cycle window.
// - trace storage is embedded block memory.
package etcc_pkg;

  // ========================================================================
  // register map (byte addresses)
  localparam int         AXI_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_COUNT    = 8'h08;
  localparam logic [7:0] REG_TRIG_POS = 8'h0c;
  localparam logic [7:0] REG_TRIG_WIN = 8'h10;
  localparam logic [7:0] REG_RD_SEL   = 8'h14;
  localparam logic [7:0] REG_RD_DATA  = 8'h18;

  // ========================================================================
  // field positions
  localparam int CTRL_ARM      = 0;
  localparam int CTRL_CFG_LSB  = 1;
  localparam int CFG_W         = 3;
  localparam int STAT_ARMED    = 0;
  localparam int STAT_CAPT     = 1;
  localparam int STAT_DONE     = 2;
  localparam int STAT_TRIG     = 3;
  localparam int STAT_OVF      = 4;
  localparam int STAT_TCNT     = 8;
  localparam int RDSEL_WORD    = 16;
  localparam int SYNC_CLK      = 0;
  localparam int SYNC_EN       = 1;
  localparam int SYNC_TRG      = 2;
  localparam int SYNC_DATA     = 3;

  // ========================================================================
  // limits and codes
  localparam int         TRACE_MAX   = 512;
  localparam int         DEPTH_MIN   = 16;
  localparam int         DEPTH_MAX   = 65536;
  localparam int         SPT_FLOOR   = 8;
  localparam int         SPT_DIV     = 256;
  localparam int         FIFO_WORDS  = 4;
  localparam int         WIN_BACK    = 2;
  localparam logic [7:0] WIN_GATED   = 8'h05;
  localparam logic [7:0] WIN_EXACT   = 8'h01;
  localparam logic [7:0] TCNT_MAX    = 8'hff;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPT, ST_DONE} etcc_state_t;
  typedef enum logic [1:0] {RP_IDLE, RP_MEM, RP_LOAD, RP_RESP}   etcc_rph_t;

  typedef struct packed {
    logic multi;
    logic gate_en;
    logic pol_low;
  } etcc_cfg_t;

  function automatic int etcc_spt_min(input int depth);
    return (depth / SPT_DIV > SPT_FLOOR) ? depth / SPT_DIV : SPT_FLOOR;
  endfunction

  function automatic logic [31:0] etcc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// File: rtl/etcc_fifo.sv
// etcc_fifo: small sample queue between capture and trace memory.
// assumes one clock; the drain side may stall at any time.
`timescale 1ns/1ps
`default_nettype none
module etcc_fifo
  import etcc_pkg::*;
#(
  parameter int W = 8,
  parameter int D = FIFO_WORDS
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem_q [D];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW:0]   cnt_q;
  wire           push = ce & in_valid & in_ready;
  wire           pop  = ce & out_valid & out_ready;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (cnt_q != (PW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= nxt(wp_q);
      end
      if (pop) begin
        rp_q <= nxt(rp_q);
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: rtl/etcc_mem.sv
// etcc_mem: single-port trace store with registered read.
// assumes write and read never target the port in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module etcc_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     aclk,
  input  wire logic                     ce,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [W-1:0]             wdata,
  output var  logic [W-1:0]             rdata_q
);
  // plain array without reset so it maps onto embedded block memory
  logic [W-1:0] ram [DEPTH];

  always_ff @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        ram[addr] <= wdata;
      end
      rdata_q <= ram[addr];
    end
  end
endmodule
`default_nettype wire

// File: rtl/etcc_core.sv
// etcc_core: trace capture core with AXI4-Lite register access.
// assumes aclk at 125 MHz; sample clock, enable, trigger and trace pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module etcc_core
  import etcc_pkg::*;
#(
  parameter int TRACE_W = TRACE_MAX,
  parameter int DEPTH   = 1024,
  parameter int SPT     = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              samp_clk,
  input  wire logic              samp_en,
  input  wire logic              trig_in,
  input  wire logic [TRACE_W-1:0] trace_in,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic              capture_done
);
  localparam int AW    = $clog2(DEPTH);
  localparam int CW    = AW + 1;
  localparam int SW    = TRACE_W + SYNC_DATA;
  localparam int WORDS = (TRACE_W + 31) / 32;

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_COUNT) || (a == REG_TRIG_POS) ||
           (a == REG_TRIG_WIN) || (a == REG_RD_SEL) || (a == REG_RD_DATA);
  endfunction

  // ========================================================================
  // pin synchronisers and sample clock edge
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy2_q;
  logic [SW-1:0] sy3_q;
  logic          clk_st_q;
  wire  [SW-1:0] pins = {trace_in, trig_in, samp_en, samp_clk};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q    <= '0;
      sy2_q    <= '0;
      sy3_q    <= '0;
      clk_st_q <= 1'b0;
    end else if (ce) begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      if (sy2_q[SYNC_CLK] == sy3_q[SYNC_CLK]) begin
        clk_st_q <= sy3_q[SYNC_CLK];
      end
    end
  end

  // a rise counts once two stages agree; needs a sample clock well below aclk/2
  wire samp_ev = ce & sy2_q[SYNC_CLK] & sy3_q[SYNC_CLK] & ~clk_st_q;

  // ========================================================================
  // AXI4-Lite write channel
  logic              aw_have_q;
  logic              w_have_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              awready_q;
  logic              wready_q;
  etcc_cfg_t         cfg_q;
  logic              cfg_wr_seen_q;
  logic [31:0]       rd_sel_q;

  wire         aw_hs     = ce & s_axi_awvalid & awready_q;
  wire         w_hs      = ce & s_axi_wvalid & wready_q;
  wire         do_wr     = ce & aw_have_q & w_have_q & ~bvalid_q;
  wire         aw_have_d = aw_hs | (aw_have_q & ~do_wr);
  wire         w_have_d  = w_hs | (w_have_q & ~do_wr);
  wire         wr_ctrl   = do_wr & (aw_addr_q == REG_CTRL);
  wire         wr_sel    = do_wr & (aw_addr_q == REG_RD_SEL);
  wire  [31:0] ctrl_img  = 32'(cfg_q) << CTRL_CFG_LSB;
  wire  [31:0] ctrl_new  = etcc_merge(ctrl_img, w_data_q, w_strb_q);
  wire         arm       = wr_ctrl & ctrl_new[CTRL_ARM];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q  <= ~w_have_d;
      bvalid_q  <= do_wr | (bvalid_q & ~s_axi_bready);
      if (do_wr) begin
        bresp_q <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      aw_addr_q <= s_axi_awaddr;
    end
    if (w_hs) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // single trigger, no gating, active-high enable after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q         <= '0;
      cfg_wr_seen_q <= 1'b0;
      rd_sel_q      <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        cfg_q         <= etcc_cfg_t'(ctrl_new[CTRL_CFG_LSB +: CFG_W]);
        cfg_wr_seen_q <= 1'b1;
      end
      if (wr_sel) begin
        rd_sel_q <= etcc_merge(rd_sel_q, w_data_q, w_strb_q);
      end
    end
  end

  // ========================================================================
  // capture control
  etcc_state_t st_q;
  etcc_state_t st_d;
  logic [CW-1:0] cap_q;
  logic [CW-1:0] seg_q;
  logic [AW-1:0] wr_addr_q;
  logic [31:0]   cyc_q;
  logic [31:0]   trig_pos_q;
  logic [7:0]    trig_win_q;
  logic [7:0]    trig_cnt_q;
  logic          ovf_q;
  logic          fifo_in_ready;
  logic          fifo_out_valid;
  logic [TRACE_W-1:0] fifo_out_data;
  logic [TRACE_W-1:0] mem_q;
  etcc_rph_t     rph_q;

  wire en_ok     = ~cfg_q.gate_en | (sy3_q[SYNC_EN] ^ cfg_q.pol_low);
  wire trig_now  = samp_ev & sy3_q[SYNC_TRG];
  wire trig_take = (st_q == ST_ARMED) & trig_now;
  wire in_win    = (st_q == ST_CAPT) | trig_take;
  // stores every sample edge in the capture window ungated, only enabled ones when gated
  wire store     = samp_ev & in_win & en_ok;
  wire push      = store & fifo_in_ready;
  wire [CW-1:0] seg_nx  = ((st_q == ST_ARMED) ? '0 : seg_q) + CW'(push);
  wire [CW-1:0] tot_nx  = cap_q + CW'(push);
  wire          full_nx = push & (tot_nx == CW'(DEPTH));
  wire          seg_end = push & cfg_q.multi & (seg_nx == CW'(SPT));
  wire          mem_rd  = (rph_q == RP_MEM);
  wire          mem_we  = fifo_out_valid & ~mem_rd;
  wire [31:0]   win_lo  = (cyc_q > 32'(WIN_BACK)) ? cyc_q - 32'(WIN_BACK) : '0;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_ARMED: begin
        if (full_nx) begin
          st_d = ST_DONE;
        end else if (trig_now) begin
          st_d = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (full_nx) begin
          st_d = ST_DONE;
        end else if (seg_end) begin
          st_d = ST_ARMED;
        end
      end
      default: begin
        st_d = st_q;
      end
    endcase
    if (arm) begin
      st_d = ST_ARMED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= ST_IDLE;
      cap_q <= '0;
      seg_q <= '0;
      cyc_q <= '0;
    end else if (ce) begin
      st_q  <= st_d;
      cap_q <= arm ? '0 : tot_nx;
      if (arm) begin
        seg_q <= '0;
      end else if (push || st_q == ST_ARMED) begin
        seg_q <= seg_nx;
      end
      if (arm) begin
        cyc_q <= '0;
      end else if (samp_ev && (st_q == ST_ARMED || st_q == ST_CAPT)) begin
        cyc_q <= cyc_q + 32'h0000_0001;
      end
    end
  end

  // the first trigger is exact ungated, a window around it when gated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_pos_q <= '0;
      trig_win_q <= '0;
      trig_cnt_q <= '0;
      ovf_q      <= 1'b0;
    end else if (ce) begin
      if (arm) begin
        trig_cnt_q <= '0;
        trig_win_q <= '0;
      end else if (trig_take) begin
        if (trig_cnt_q == '0) begin
          trig_pos_q <= cfg_q.gate_en ? win_lo : cyc_q;
          trig_win_q <= cfg_q.gate_en ? WIN_GATED : WIN_EXACT;
        end
        if (trig_cnt_q != TCNT_MAX) begin
          trig_cnt_q <= trig_cnt_q + 8'h01;
        end
      end
      if (store && !fifo_in_ready) begin
        ovf_q <= 1'b1;
      end else if (arm) begin
        ovf_q <= 1'b0;
      end
    end
  end

  etcc_fifo #(.W(TRACE_W), .D(FIFO_WORDS)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (store),
    .in_ready  (fifo_in_ready),
    .in_data   (sy3_q[SYNC_DATA +: TRACE_W]),
    .out_valid (fifo_out_valid),
    .out_ready (~mem_rd),
    .out_data  (fifo_out_data)
  );

  // host readout steals the port for one cycle and stalls the drain
  etcc_mem #(.W(TRACE_W), .DEPTH(DEPTH)) u_mem (
    .aclk    (aclk),
    .ce      (ce),
    .we      (mem_we),
    .addr    (mem_rd ? rd_sel_q[AW-1:0] : wr_addr_q),
    .wdata   (fifo_out_data),
    .rdata_q (mem_q)
  );

  // buffer written only while draining a capture; kept until the next arm
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr_q    <= '0;
      capture_done <= 1'b0;
    end else if (ce) begin
      if (arm) begin
        wr_addr_q <= '0;
      end else if (mem_we) begin
        wr_addr_q <= wr_addr_q + 1'b1;
      end
      capture_done <= (st_q == ST_DONE) & ~fifo_out_valid & ~arm;
    end
  end

  // ========================================================================
  // AXI4-Lite read channel
  logic [AXI_AW-1:0] ar_addr_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  etcc_rph_t         rph_d;

  wire ar_hs = ce & s_axi_arvalid & arready_q;
  wire [WORDS*32-1:0] rd_pad  = (WORDS*32)'(mem_q);
  wire [15:0]         rd_widx = rd_sel_q[RDSEL_WORD +: 16];
  wire [31:0] mem_word = (rd_widx < 16'(WORDS)) ? rd_pad[32*rd_widx +: 32] : '0;
  wire [31:0] stat_w   = (32'(trig_cnt_q) << STAT_TCNT) | (32'(ovf_q) << STAT_OVF) |
                         (32'(trig_cnt_q != '0) << STAT_TRIG) | (32'(capture_done) << STAT_DONE) |
                         (32'(st_q == ST_CAPT) << STAT_CAPT) | (32'(st_q == ST_ARMED) << STAT_ARMED);
  wire [31:0] rd_word  = (ar_addr_q == REG_CTRL)     ? ctrl_img :
                         (ar_addr_q == REG_STATUS)   ? stat_w :
                         (ar_addr_q == REG_COUNT)    ? 32'(cap_q) :
                         (ar_addr_q == REG_TRIG_POS) ? trig_pos_q :
                         (ar_addr_q == REG_TRIG_WIN) ? 32'(trig_win_q) :
                         (ar_addr_q == REG_RD_SEL)   ? rd_sel_q :
                         (ar_addr_q == REG_RD_DATA)  ? mem_word : '0;

  always_comb begin
    rph_d = rph_q;
    case (rph_q)
      RP_IDLE: begin
        if (ar_hs) begin
          rph_d = RP_MEM;
        end
      end
      RP_MEM: begin
        rph_d = RP_LOAD;
      end
      RP_LOAD: begin
        rph_d = RP_RESP;
      end
      default: begin
        if (s_axi_rready) begin
          rph_d = RP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rph_q     <= RP_IDLE;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
      ar_addr_q <= '0;
    end else if (ce) begin
      rph_q     <= rph_d;
      arready_q <= (rph_d == RP_IDLE);
      rvalid_q  <= (rph_d == RP_RESP);
      if (ar_hs) begin
        ar_addr_q <= s_axi_araddr;
      end
      if (rph_q == RP_LOAD) begin
        rdata_q <= rd_word;
        rresp_q <= is_mapped(ar_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  trace_width_a: assert property (TRACE_W >= 1 && TRACE_W <= TRACE_MAX)
    else $error("trace width out of range");
  depth_pow2_a: assert property (DEPTH >= DEPTH_MIN && DEPTH <= DEPTH_MAX && (DEPTH & (DEPTH - 1)) == 0)
    else $error("buffer depth not a legal power of two");
  spt_floor_a: assert property (SPT >= etcc_spt_min(DEPTH))
    else $error("samples per trigger below floor");
  mode_default_a: assert property (!cfg_wr_seen_q |-> !cfg_q.multi)
    else $error("multiple mode active without configuration");
  gate_default_a: assert property (!cfg_wr_seen_q |-> !cfg_q.gate_en)
    else $error("gating active without configuration");
  pol_default_a: assert property (!cfg_wr_seen_q |-> !cfg_q.pol_low)
    else $error("enable polarity not high by default");
  ungated_store_a: assert property ((st_q == ST_CAPT && samp_ev && !cfg_q.gate_en && fifo_in_ready)
                                    |-> push ##1 cap_q == $past(cap_q) + 1'b1)
    else $error("ungated sample edge not stored");
  gated_store_a: assert property (push |-> samp_ev && (!cfg_q.gate_en || sy3_q[SYNC_EN] != cfg_q.pol_low))
    else $error("sample stored while enable inactive");
  trig_skip_a: assert property ((trig_take && !en_ok && !arm) |=> cap_q == $past(cap_q))
    else $error("trigger cycle stored while enable inactive");
  trig_win_a: assert property ((trig_take && trig_cnt_q == '0 && cfg_q.gate_en && !arm)
                               |=> trig_win_q == WIN_GATED && trig_pos_q == $past(win_lo))
    else $error("gated trigger window not reported");
  buf_hold_a: assert property ((capture_done && !arm) |-> !mem_we ##1 wr_addr_q == $past(wr_addr_q))
    else $error("buffer written after capture finished");
  rd_latency_a: assert property ((ar_hs ##1 ce [*2]) |=> s_axi_rvalid)
    else $error("read answer late");
  rvalid_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

  single_done_c: cover property (!cfg_q.multi && $rose(capture_done));
  multi_done_c: cover property (cfg_q.multi && trig_cnt_q > 8'h01 && $rose(capture_done));
  gated_skip_c: cover property (trig_take && !en_ok);
  overflow_c: cover property (store && !fifo_in_ready);
endmodule
`default_nettype wire

// File: dv/etcc_src.sv
// etcc_src: traced-design side of the capture core: sample clock, enable, trigger, counting trace bus.
// assumes the bench sets the trigger level and whether the enable toggles.
`timescale 1ns/1ps
`default_nettype none
module etcc_src #(
  parameter int W = 64
) (
  input  wire logic         trig_lvl,
  input  wire logic         en_tog,
  output var  logic         samp_clk,
  output var  logic         samp_en,
  output var  logic         trig_in,
  output var  logic [W-1:0] trace_in
);
  // ========================================================================
  // free-running sample clock, data moves on its falling edge
  logic [31:0] cnt_q;
  initial begin
    samp_clk = 1'b0;
    cnt_q = 32'h0;
  end
  always #62.5 samp_clk = ~samp_clk;
  always @(negedge samp_clk) cnt_q <= cnt_q + 32'h1;
  assign trace_in = {(W/32){cnt_q}};
  // enable follows count parity, so only every other sample clock is active
  assign samp_en  = en_tog ? cnt_q[0] : 1'b1;
  assign trig_in  = trig_lvl;
endmodule
`default_nettype wire

// File: dv/etcc_core_bench.sv
// etcc_core_bench: self-checking bench for the trace capture core.
// assumes etcc_src drives the traced side; registers reached over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module etcc_core_bench;
  import etcc_pkg::*;
  localparam int TW = 64;
  localparam int DP = 16;
  localparam int SP = 8;
  logic          aclk, aresetn, trig_lvl, en_tog, samp_clk, samp_en, trig_in, capture_done;
  logic [TW-1:0] trace_in;
  logic [7:0]    awaddr, araddr;
  logic          awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp;
  int            fails, num_checks;

  always #4 aclk = ~aclk;
  etcc_src #(.W(TW)) src (.trig_lvl(trig_lvl), .en_tog(en_tog), .samp_clk(samp_clk), .samp_en(samp_en),
    .trig_in(trig_in), .trace_in(trace_in));
  etcc_core #(.TRACE_W(TW), .DEPTH(DP), .SPT(SP)) dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .samp_clk(samp_clk), .samp_en(samp_en), .trig_in(trig_in), .trace_in(trace_in), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_done(capture_done));

  // ========================================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(inout int k);
    @(posedge aclk);
    k++;
    if (k > 5000) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      tick(k);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
    tick(k);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      tick(k);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    tick(k);
  endtask

  // ========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] v;
    rd(REG_CTRL, v, RESP_OKAY);
    chk(v, 32'h0);
    rd(REG_TRIG_WIN, v, RESP_OKAY);
    chk(v, 32'h0);
    wr(8'h1c, 32'hff, RESP_SLVERR);
    rd(8'h1c, v, RESP_SLVERR);
    chk(v, 32'h0);
  endtask
  // arm, trigger, wait for completion, then read back and compare samples
  task automatic run_cap(input logic [31:0] ctl, input int stride, input int n, input logic [7:0] win,
                         output logic [31:0] b);
    logic [31:0] v;
    int k;
    k = 0;
    wr(REG_CTRL, ctl, RESP_OKAY);
    trig_lvl <= 1'b1;
    while (capture_done !== 1'b1) tick(k);
    trig_lvl <= 1'b0;
    rd(REG_COUNT, v, RESP_OKAY);
    chk(v, 32'(DP));
    rd(REG_TRIG_WIN, v, RESP_OKAY);
    chk(v, {24'h0, win});
    for (int i = 0; i < n; i++) begin
      wr(REG_RD_SEL, 32'(i), RESP_OKAY);
      rd(REG_RD_DATA, v, RESP_OKAY);
      if (i == 0) b = v;
      chk(v, b + 32'(stride * i));
    end
    wr(REG_RD_SEL, 32'h0001_0000, RESP_OKAY);
    rd(REG_RD_DATA, v, RESP_OKAY);
    chk(v, b);
  endtask
  task automatic t_single;
    logic [31:0] b;
    en_tog <= 1'b0;
    run_cap(32'h1, 1, DP, WIN_EXACT, b);
  endtask
  task automatic t_gated;
    logic [31:0] b;
    en_tog <= 1'b1;
    run_cap(32'h5, 2, DP, WIN_GATED, b);
    chk(32'(b[0]), 32'h1);
    run_cap(32'h7, 2, DP, WIN_GATED, b);
    chk(32'(b[0]), 32'h0);
  endtask
  task automatic t_multi;
    logic [31:0] b, v;
    en_tog <= 1'b0;
    run_cap(32'h9, 1, SP, WIN_EXACT, b);
    rd(REG_STATUS, v, RESP_OKAY);
    chk(v, (32'(DP / SP) << STAT_TCNT) | (32'h1 << STAT_TRIG) | (32'h1 << STAT_DONE));
  endtask

  initial begin
    {aclk, trig_lvl, en_tog, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_single();
    t_gated();
    t_multi();
    report_and_stop();
  end
endmodule
`default_nettype wire
